// >>> hdc_pkg.sv
// Package with register map, field positions, timing and state types of the haptic control block.
package hdc_pkg;

  // Register offsets.
  localparam logic [7:0] REG_STATUS   = 8'h00;
  localparam logic [7:0] REG_MODE     = 8'h01;
  localparam logic [7:0] REG_DIRECT   = 8'h02;
  localparam logic [7:0] REG_LAUNCH   = 8'h0c;
  localparam logic [7:0] REG_FUSE_LO  = 8'h16;
  localparam logic [7:0] REG_ODLIM    = 8'h17;
  localparam logic [7:0] REG_FUSE_HI  = 8'h1a;
  localparam logic [7:0] REG_LOOP     = 8'h1d;
  localparam logic [7:0] REG_FUSE     = 8'h1e;
  localparam logic [7:0] REG_OLPER    = 8'h20;
  localparam logic [7:0] REG_RESPER   = 8'h22;

  // Number of fuse backed bytes and their indices inside the fuse window.
  localparam int          FUSE_BYTES  = 5;
  localparam logic [2:0] IDX_RATED   = 3'h0;
  localparam logic [2:0] IDX_ODLIM   = 3'h1;
  localparam logic [2:0] IDX_COMP    = 3'h2;
  localparam logic [2:0] IDX_BEMF    = 3'h3;
  localparam logic [2:0] IDX_FEEDBK  = 3'h4;

  // Field positions.
  localparam int BIT_DIAG      = 3;
  localparam int BIT_ID_LSB    = 5;
  localparam int BIT_SOFTRST   = 7;
  localparam int BIT_STANDBY   = 6;
  localparam int BIT_LAUNCH    = 0;
  localparam int BIT_ACT_TYPE  = 7;
  localparam int BIT_BIDIR     = 7;
  localparam int BIT_ROT_OL    = 5;
  localparam int BIT_SIGNED    = 3;
  localparam int BIT_ANALOG    = 1;
  localparam int BIT_LIN_OL    = 0;
  localparam int BIT_FUSE_PROG = 0;
  localparam int BIT_FUSE_STAT = 2;

  // Write masks, reserved bits stay zero.
  localparam logic [7:0] MODE_WMASK  = 8'h47;
  localparam logic [7:0] OLPER_WMASK = 8'h7f;

  // Operating selector values.
  localparam logic [2:0] MODE_PWM    = 3'h3;
  localparam logic [2:0] MODE_DIRECT = 3'h5;
  localparam logic [2:0] MODE_CAL    = 3'h7;

  // Reset values.
  localparam logic [7:0] MODE_RST    = 8'h40;
  localparam logic [7:0] LOOP_RST    = 8'h80;
  localparam logic [7:0] OLPER_RST   = 8'h33;
  localparam logic [7:0] RATED_RST   = 8'h40;
  localparam logic [7:0] ODLIM_RST   = 8'h80;
  localparam logic [7:0] BYTE_ZERO   = 8'h00;

  // Drive scaling.
  localparam logic [8:0] MID_SCALE   = 9'h080;
  localparam int         BIP_SHIFT   = 7;
  localparam int         UNI_SHIFT   = 8;

  // Timing at the 40 MHz reference clock.
  localparam int CLK_HZ          = 40000000;
  localparam int CAL_TIME_US     = 1000;
  localparam int CAL_CYCLES      = CLK_HZ / 1000000 * CAL_TIME_US;
  localparam int HALF_UNIT_NS    = 49230;
  localparam int HALF_UNIT_CYC   = HALF_UNIT_NS * (CLK_HZ / 1000000) / 1000;
  localparam int PWM_DIV         = 128;
  localparam logic [5:0] PWM_EDGE_LAST = 6'(PWM_DIV / 2 - 1);

  // Register port request.
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } hdc_req_s;

  // Calibration engine states.
  typedef enum logic [1:0] {
    CAL_IDLE = 2'b00,
    CAL_RUN  = 2'b01,
    CAL_DONE = 2'b10
  } hdc_cal_e;

  typedef logic [FUSE_BYTES-1:0][7:0] hdc_fuse_t;

  // Complete state of the control core.
  typedef struct packed {
    logic [7:0]  mode;
    logic [7:0]  direct;
    logic        launch;
    hdc_fuse_t   cfg;
    logic [7:0]  loopc;
    logic [7:0]  olper;
    logic [7:0]  resper;
    hdc_fuse_t   fuse;
    logic        burned;
    logic        diag;
    hdc_cal_e    cal;
    logic [23:0] cal_cnt;
    logic        lock_seen;
    logic [17:0] per_cnt;
    logic [5:0]  edge_cnt;
    logic        pwm_prev;
    logic        zc_prev;
    logic        comm;
    logic [7:0]  rdata;
    logic        rvalid;
    logic [7:0]  drive_level;
    logic        drive_neg;
    logic        phase;
    logic        reverse;
    logic        cal_busy;
  } hdc_core_s;

  // State of the drive shaper.
  typedef struct packed {
    logic [7:0] mag;
    logic       neg;
  } hdc_shp_s;

endpackage

// >>> hdc_drive_shaper.sv
// Drive shaper that turns an eight-bit playback value into a magnitude and a direction.
`timescale 1ns/100ps
module hdc_drive_shaper (
  input  wire logic       ref_clk,
  input  wire logic       nrst,
  input  wire logic [7:0] raw,
  input  wire logic       unsigned_fmt,
  input  wire logic       open_loop,
  input  wire logic       bidir,
  input  wire logic [7:0] od_limit,
  input  wire logic [7:0] rated,
  input  wire logic       brake_req,
  output logic      [7:0] mag,
  output logic            neg
);

  hdc_pkg::hdc_shp_s s_reg;
  hdc_pkg::hdc_shp_s s_next;
  logic signed [8:0] rel;
  logic [7:0]        absval;
  logic [16:0]       bip_prod;
  logic [16:0]       uni_prod;
  logic [8:0]        bip_ref;
  logic [8:0]        uni_val;
  logic [8:0]        lvl;

  // Scaling adds one reference step so that full scale lands exactly on the reference.
  always_comb begin
    s_next = s_reg;
    rel = unsigned_fmt ? ($signed({1'b0, raw}) - $signed(hdc_pkg::MID_SCALE))
                       : $signed({raw[7], raw});
    absval = rel[8] ? 8'(-rel) : rel[7:0];
    bip_ref = open_loop ? {1'b0, od_limit} : {1'b0, rated};
    bip_prod = 17'(absval) * 17'(bip_ref) + 17'(bip_ref);
    uni_prod = 17'(raw) * 17'(rated) + 17'(rated);
    uni_val = 9'(uni_prod >> hdc_pkg::UNI_SHIFT);
    lvl = (absval == 8'h00) ? 9'h000 : 9'(bip_prod >> hdc_pkg::BIP_SHIFT);
    s_next.neg = 1'b0;
    if (open_loop) begin
      s_next.neg = rel[8];
    end else if (!bidir) begin
      lvl = uni_val;
    end else if (rel[8]) begin
      lvl = 9'h000;
    end
    if (!open_loop && brake_req) begin
      lvl = {1'b0, od_limit};
      s_next.neg = 1'b1;
    end
    // Nothing ever exceeds the peak limit, whatever the mode.
    s_next.mag = (lvl > {1'b0, od_limit}) ? od_limit : lvl[7:0];
  end

  // State register.
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign mag = s_reg.mag;
  assign neg = s_reg.neg;

endmodule

// >>> hdc_core.sv
// Control core of the haptic driver: registers, calibration, fuse memory and drive steering.
//
// Function
// - Linear open loop on pulse-width input commutates at input frequency over 128.
// - Without pulse-width input, linear open-loop period comes from the seven-bit field.
// - Closed loop regulates level and, for linear, tracks drive frequency.
// - Rotary calibration ignores linear-only inputs.
// - Writing 0x07 to the mode register leaves standby and selects calibration.
// - Launch bit starts calibration, clears itself at the end, results stored.
// - Calibration faults show in the diagnostic fail flag.
// - Calibration contents survive standby and enable low.
// - Fuse memory accepts only one programming.
// - Writing mode_control to the fuse register programs it; status then reads 1.
// - Soft reset reloads fuse-backed registers from fuse memory once burned, else defaults; power-up clears the fuse and loads defaults.
// - Open loop scales full scale to the peak limit, mid-scale zero, below negative.
// - Negative open-loop drive reverses rotary or shifts linear phase by half a cycle.
// - Direct values are eight bits, signed or unsigned by the signedness bit.
// - Closed-loop unidirectional uses full range scaled to the nominal level.
// - Closed loop never exceeds the peak limit and brakes on feedback demand.
// - Closed-loop bidirectional: mid-scale and below give zero drive.
// - Power-up default is closed-loop bidirectional.
// - Selector value 5 gives direct playback at the written amplitude.
`timescale 1ns/100ps
module hdc_core #(
  parameter int         CAL_CYCLES    = hdc_pkg::CAL_CYCLES,
  parameter int         HALF_UNIT_CYC = hdc_pkg::HALF_UNIT_CYC,
  parameter logic [2:0] DEVICE_CODE   = 3'h5
) (
  input  wire logic             ref_clk,
  input  wire logic             nrst,
  input  wire logic             en,
  input  wire hdc_pkg::hdc_req_s req,
  input  wire logic             pwm_in,
  input  wire logic [7:0]       pwm_duty,
  input  wire logic             zero_cross,
  input  wire logic             brake_req,
  input  wire logic             res_lock,
  input  wire logic             bemf_ok,
  input  wire logic [7:0]       cal_comp_in,
  input  wire logic [7:0]       cal_bemf_in,
  input  wire logic [7:0]       res_period_in,
  output logic      [7:0]       reg_rdata,
  output logic                  reg_rvalid,
  output logic      [7:0]       drive_level,
  output logic                  drive_neg,
  output logic                  comm_phase,
  output logic                  reverse_drive,
  output logic                  cal_busy
);

  // DEVICE_CODE is an arbitrary neutral value, not a real part code.
  initial begin
    if (CAL_CYCLES < 1 || CAL_CYCLES >= (1 << 24)) begin
      $error("CAL_CYCLES out of range");
    end
    if (HALF_UNIT_CYC < 1 || HALF_UNIT_CYC >= (1 << 11)) begin
      $error("HALF_UNIT_CYC out of range");
    end
  end

  localparam logic [23:0] CAL_LAST  = 24'(CAL_CYCLES - 1);
  localparam logic [10:0] HALF_UNIT = 11'(HALF_UNIT_CYC);

  hdc_pkg::hdc_core_s s_reg;
  hdc_pkg::hdc_core_s s_next;
  hdc_pkg::hdc_core_s rst_val;

  logic       linear;
  logic       rot_ol;
  logic       lin_ol;
  logic       open_loop;
  logic       standby;
  logic [2:0] sel;
  logic       pwm_use;
  logic       active;
  logic [7:0] shp_raw;
  logic [7:0] shp_mag;
  logic       shp_neg;
  logic       pwm_edge;
  logic       zc_edge;
  logic [17:0] half_limit;
  logic [2:0] fidx;
  logic       in_fuse;

  // Decoded configuration.
  assign linear    = s_reg.cfg[hdc_pkg::IDX_FEEDBK][hdc_pkg::BIT_ACT_TYPE];
  assign rot_ol    = s_reg.loopc[hdc_pkg::BIT_ROT_OL];
  assign lin_ol    = s_reg.loopc[hdc_pkg::BIT_LIN_OL];
  assign open_loop = linear ? lin_ol : rot_ol;
  assign standby   = s_reg.mode[hdc_pkg::BIT_STANDBY];
  assign sel       = s_reg.mode[2:0];
  assign pwm_use   = (sel == hdc_pkg::MODE_PWM) && !s_reg.loopc[hdc_pkg::BIT_ANALOG];
  assign active    = en && !standby && ((sel == hdc_pkg::MODE_DIRECT) || pwm_use);
  assign shp_raw   = (sel == hdc_pkg::MODE_DIRECT) ? s_reg.direct : pwm_duty;
  assign pwm_edge  = pwm_in && !s_reg.pwm_prev;
  assign zc_edge   = zero_cross && !s_reg.zc_prev;
  assign half_limit = 18'(s_reg.olper[6:0]) * 18'(HALF_UNIT);
  assign fidx      = 3'(req.addr - hdc_pkg::REG_FUSE_LO);
  assign in_fuse   = (req.addr >= hdc_pkg::REG_FUSE_LO) && (req.addr <= hdc_pkg::REG_FUSE_HI);

  // Drive value shaping per loop mode.
  hdc_drive_shaper u_shaper (
    .ref_clk      (ref_clk),
    .nrst         (nrst),
    .raw          (shp_raw),
    .unsigned_fmt (s_reg.loopc[hdc_pkg::BIT_SIGNED]),
    .open_loop    (open_loop),
    .bidir        (s_reg.loopc[hdc_pkg::BIT_BIDIR]),
    .od_limit     (s_reg.cfg[hdc_pkg::IDX_ODLIM]),
    .rated        (s_reg.cfg[hdc_pkg::IDX_RATED]),
    .brake_req    (brake_req),
    .mag          (shp_mag),
    .neg          (shp_neg)
  );

  // Reset image: every register to its default, fuse-backed bytes from fuse once burned.
  // The fuse contents and the burned mark are carried over so a soft reset keeps them.
  always_comb begin
    rst_val = '0;
    rst_val.mode = hdc_pkg::MODE_RST;
    rst_val.loopc = hdc_pkg::LOOP_RST;
    rst_val.olper = hdc_pkg::OLPER_RST;
    rst_val.cal = hdc_pkg::CAL_IDLE;
    rst_val.fuse = s_reg.fuse;
    rst_val.burned = s_reg.burned;
    if (s_reg.burned) begin
      rst_val.cfg = s_reg.fuse;
    end else begin
      rst_val.cfg[hdc_pkg::IDX_RATED] = hdc_pkg::RATED_RST;
      rst_val.cfg[hdc_pkg::IDX_ODLIM] = hdc_pkg::ODLIM_RST;
    end
  end

  // Next state.
  always_comb begin
    s_next = s_reg;
    s_next.rvalid = 1'b0;
    s_next.pwm_prev = pwm_in;
    s_next.zc_prev = zero_cross;

    // Calibration engine; start and run freeze while enable is low so nothing is lost.
    case (s_reg.cal)
      hdc_pkg::CAL_IDLE: begin
        if (en && s_reg.launch && !standby && sel == hdc_pkg::MODE_CAL) begin
          s_next.cal = hdc_pkg::CAL_RUN;
          s_next.cal_cnt = '0;
          s_next.lock_seen = 1'b0;
          s_next.diag = 1'b0;
        end
      end
      hdc_pkg::CAL_RUN: begin
        if (en) begin
          s_next.cal_cnt = s_reg.cal_cnt + 24'h000001;
          if (res_lock && linear) begin
            s_next.lock_seen = 1'b1;
          end
          if (s_reg.cal_cnt == CAL_LAST) begin
            s_next.cal = hdc_pkg::CAL_DONE;
          end
        end
      end
      hdc_pkg::CAL_DONE: begin
        // Results land in the output registers and the launch bit drops.
        s_next.cfg[hdc_pkg::IDX_COMP] = cal_comp_in;
        s_next.cfg[hdc_pkg::IDX_BEMF] = cal_bemf_in;
        if (linear) begin
          s_next.resper = res_period_in;
        end
        // A rotary motor is judged on back-EMF alone; lock is a linear-only input.
        s_next.diag = !bemf_ok || (linear && !s_reg.lock_seen);
        s_next.launch = 1'b0;
        s_next.cal = hdc_pkg::CAL_IDLE;
      end
      default: begin
        s_next.cal = hdc_pkg::CAL_IDLE;
      end
    endcase

    // Commutation timing for the linear actuator.
    if (!linear) begin
      s_next.comm = 1'b0;
      s_next.per_cnt = '0;
      s_next.edge_cnt = '0;
    end else if (!open_loop) begin
      if (zc_edge) begin
        s_next.comm = !s_reg.comm;
      end
    end else if (pwm_use) begin
      if (pwm_edge) begin
        s_next.edge_cnt = s_reg.edge_cnt + 6'h01;
        if (s_reg.edge_cnt == hdc_pkg::PWM_EDGE_LAST) begin
          s_next.edge_cnt = '0;
          s_next.comm = !s_reg.comm;
        end
      end
    end else begin
      // A zero period flips the phase on every clock rather than stalling it.
      if (s_reg.per_cnt + 18'h00001 >= half_limit) begin
        s_next.per_cnt = '0;
        s_next.comm = !s_reg.comm;
      end else begin
        s_next.per_cnt = s_reg.per_cnt + 18'h00001;
      end
    end

    // Drive outputs; only direct playback and pulse-width modes drive here.
    s_next.drive_level = active ? shp_mag : 8'h00;
    s_next.drive_neg = active && shp_neg;
    s_next.phase = linear && (s_reg.comm ^ (active && shp_neg));
    s_next.reverse = !linear && active && shp_neg;
    s_next.cal_busy = (s_reg.cal != hdc_pkg::CAL_IDLE);

    // Host writes come last so a host set wins over a same-cycle hardware clear.
    // Writes are ignored while enable is low, which also keeps the settings intact.
    if (req.wr && en) begin
      if (in_fuse) begin
        s_next.cfg[fidx] = req.wdata;
      end
      case (req.addr)
        hdc_pkg::REG_MODE: begin
          if (req.wdata[hdc_pkg::BIT_SOFTRST]) begin
            s_next = rst_val;
          end else begin
            s_next.mode = req.wdata & hdc_pkg::MODE_WMASK;
          end
        end
        hdc_pkg::REG_DIRECT: begin
          s_next.direct = req.wdata;
        end
        hdc_pkg::REG_LAUNCH: begin
          s_next.launch = req.wdata[hdc_pkg::BIT_LAUNCH] || (s_next.cal != hdc_pkg::CAL_IDLE);
        end
        hdc_pkg::REG_LOOP: begin
          s_next.loopc = req.wdata;
        end
        hdc_pkg::REG_OLPER: begin
          s_next.olper = req.wdata & hdc_pkg::OLPER_WMASK;
        end
        hdc_pkg::REG_FUSE: begin
          if (req.wdata[hdc_pkg::BIT_FUSE_PROG] && !s_reg.burned) begin
            s_next.fuse = s_reg.cfg;
            s_next.burned = 1'b1;
          end
        end
        default: begin
        end
      endcase
    end

    // Read answer one cycle after the request.
    if (req.rd) begin
      s_next.rvalid = 1'b1;
      s_next.rdata = 8'h00;
      if (in_fuse) begin
        s_next.rdata = s_reg.cfg[fidx];
      end
      case (req.addr)
        hdc_pkg::REG_STATUS: begin
          s_next.rdata[7:hdc_pkg::BIT_ID_LSB] = DEVICE_CODE;
          s_next.rdata[hdc_pkg::BIT_DIAG] = s_reg.diag;
        end
        hdc_pkg::REG_MODE: begin
          s_next.rdata = s_reg.mode;
        end
        hdc_pkg::REG_DIRECT: begin
          s_next.rdata = s_reg.direct;
        end
        hdc_pkg::REG_LAUNCH: begin
          s_next.rdata[hdc_pkg::BIT_LAUNCH] = s_reg.launch;
        end
        hdc_pkg::REG_LOOP: begin
          s_next.rdata = s_reg.loopc;
        end
        hdc_pkg::REG_FUSE: begin
          s_next.rdata[hdc_pkg::BIT_FUSE_STAT] = s_reg.burned;
        end
        hdc_pkg::REG_OLPER: begin
          s_next.rdata = s_reg.olper;
        end
        hdc_pkg::REG_RESPER: begin
          s_next.rdata = s_reg.resper;
        end
        default: begin
        end
      endcase
    end
  end

  // State register; calibration data is changed by reset, calibration and host writes, never by standby or enable.
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      s_reg <= '{mode: hdc_pkg::MODE_RST, loopc: hdc_pkg::LOOP_RST, olper: hdc_pkg::OLPER_RST,
                 cfg: {hdc_pkg::BYTE_ZERO, hdc_pkg::BYTE_ZERO, hdc_pkg::BYTE_ZERO,
                       hdc_pkg::ODLIM_RST, hdc_pkg::RATED_RST},
                 cal: hdc_pkg::CAL_IDLE, default: '0};
    end else begin
      s_reg <= s_next;
    end
  end

  // Outputs straight from the state register.
  assign reg_rdata     = s_reg.rdata;
  assign reg_rvalid    = s_reg.rvalid;
  assign drive_level   = s_reg.drive_level;
  assign drive_neg     = s_reg.drive_neg;
  assign comm_phase    = s_reg.phase;
  assign reverse_drive = s_reg.reverse;
  assign cal_busy      = s_reg.cal_busy;

endmodule

// >>> hdc_core_assertions.sv
// Concurrent checks on the ports of the haptic control core.
`timescale 1ns/100ps
module hdc_core_checker #(
  parameter int         CAL_CYCLES    = 8,
  parameter int         HALF_UNIT_CYC = 2,
  parameter logic [2:0] DEVICE_CODE   = 3'h5
) (
  input wire logic              ref_clk,
  input wire logic              nrst,
  input wire logic              en,
  input wire hdc_pkg::hdc_req_s req,
  input wire logic [7:0]        reg_rdata,
  input wire logic              reg_rvalid,
  input wire logic [7:0]        drive_level,
  input wire logic              comm_phase,
  input wire logic              cal_busy
);
  logic [7:0]  od_reg;
  logic        lin_reg;
  logic [7:0]  rd_addr_reg;
  logic        fuse_seen_reg;
  logic [15:0] busy_cnt_reg;
  logic        wr_ok;

  assign wr_ok = req.wr && en;

  // Shadows of host writes; soft reset is trusted only once the fuse holds the same values.
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      od_reg        <= hdc_pkg::ODLIM_RST;
      lin_reg       <= 1'b0;
      rd_addr_reg   <= 8'h00;
      fuse_seen_reg <= 1'b0;
      busy_cnt_reg  <= 16'h0000;
    end else begin
      if (wr_ok && req.addr == hdc_pkg::REG_ODLIM) od_reg <= req.wdata;
      if (wr_ok && req.addr == hdc_pkg::REG_FUSE_HI) lin_reg <= req.wdata[7];
      if (req.rd) rd_addr_reg <= req.addr;
      if (reg_rvalid && rd_addr_reg == hdc_pkg::REG_FUSE && reg_rdata[2]) fuse_seen_reg <= 1'b1;
      if (!cal_busy) busy_cnt_reg <= 16'h0000;
      else if (en) busy_cnt_reg <= busy_cnt_reg + 16'h0001;
    end
  end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!nrst);

  sequence s_launch_poll;
    req.rd && req.addr == hdc_pkg::REG_LAUNCH;
  endsequence

  a_read_answer: assert property (req.rd |=> reg_rvalid)
    else $error("read request not answered one cycle later");
  a_launch_running: assert property ($rose(cal_busy) ##[0:3] s_launch_poll |=> reg_rdata[0])
    else $error("launch bit read as zero while calibration runs");
  a_launch_clear: assert property ($fell(cal_busy) ##[0:2] s_launch_poll |=> !reg_rdata[0])
    else $error("launch bit still set after calibration ended");
  a_cal_length: assert property ($fell(cal_busy) |->
      busy_cnt_reg >= CAL_CYCLES && busy_cnt_reg <= CAL_CYCLES + 3)
    else $error("calibration run length wrong");
  a_od_ceiling: assert property (drive_level <= od_reg)
    else $error("drive level above the peak limit");
  a_rotary_phase: assert property (!lin_reg [*4] |-> !comm_phase)
    else $error("commutation phase moves with a rotary motor");
  a_idle_drive: assert property (!en [*3] |-> drive_level == 8'h00)
    else $error("drive present while enable is low");
  a_fuse_sticky: assert property (reg_rvalid && rd_addr_reg == hdc_pkg::REG_FUSE
      && fuse_seen_reg |-> reg_rdata[2])
    else $error("fuse status bit fell back to zero");
  a_reset_quiet: assert property (disable iff (1'b0) !nrst |=>
      drive_level == 8'h00 && !cal_busy && !reg_rvalid)
    else $error("outputs active during reset");
endmodule

bind hdc_core hdc_core_checker #(
  .CAL_CYCLES   (CAL_CYCLES),
  .HALF_UNIT_CYC(HALF_UNIT_CYC),
  .DEVICE_CODE  (DEVICE_CODE)
) i_hdc_core_checker (
  .ref_clk    (ref_clk),
  .nrst       (nrst),
  .en         (en),
  .req        (req),
  .reg_rdata  (reg_rdata),
  .reg_rvalid (reg_rvalid),
  .drive_level(drive_level),
  .comm_phase (comm_phase),
  .cal_busy   (cal_busy)
);

// >>> hdc_host_model.sv
// Host processor model issuing single-byte register requests after the bus decoder.
`timescale 1ns/100ps
module hdc_host_model (
  input  wire logic        ref_clk,
  output hdc_pkg::hdc_req_s req
);
  hdc_pkg::hdc_req_s pend[$];

  initial req = '{wr: 1'b0, rd: 1'b0, addr: 8'h5a, wdata: 8'ha5};

  // One request per cycle; idle fields invert so a stale address never looks valid.
  always @(negedge ref_clk) begin
    if (pend.size() > 0) begin
      req <= pend.pop_front();
    end else begin
      req <= '{wr: 1'b0, rd: 1'b0, addr: ~req.addr, wdata: ~req.wdata};
    end
  end

  task automatic put(input hdc_pkg::hdc_req_s r);
    pend.push_back(r);
  endtask

  function automatic int pending();
    return pend.size();
  endfunction
endmodule

// >>> tb.sv
// Self-checking testbench of the haptic control core.
`timescale 1ns/100ps
module tb;
  logic              ref_clk = 1'b0;
  logic              nrst = 1'b0;
  logic              en = 1'b1;
  hdc_pkg::hdc_req_s req;
  logic              pwm_in = 1'b0;
  logic              pwm_run = 1'b0;
  logic              brake_req = 1'b0;
  logic              res_lock = 1'b0;
  logic              bemf_ok = 1'b1;
  logic [7:0]        comp_in = 8'h00;
  logic [7:0]        bemf_in = 8'h00;
  logic [7:0]        per_in = 8'h00;
  logic [7:0]        reg_rdata;
  logic [7:0]        drive_level;
  logic              reg_rvalid;
  logic              drive_neg;
  logic              comm_phase;
  logic              reverse_drive;
  logic              cal_busy;
  logic [7:0]        raw;
  logic [8:0]        e;
  logic [15:0]       note;
  logic [15:0]       exp_q[$];
  int                fail_count = 0;
  int                compares = 0;
  int                cycles = 0;
  logic [7:0]        cfg_tab [5] = '{8'h20, 8'h28, 8'h08, 8'h80, 8'h88};
  logic [7:0]        raw_tab [4] = '{8'h80, 8'h7f, 8'h00, 8'hff};
  logic [3:0]        cal_tab [4] = '{4'b0100, 4'b1101, 4'b1110, 4'b0011};
  logic [7:0]        fz [5] = '{8'h90, 8'ha0, 8'h3e, 8'h5c, 8'h00};
  logic [7:0]        rst_a [7] = '{8'h01, 8'h1d, 8'h20, 8'h16, 8'h17, 8'h1a, 8'h05};
  logic [7:0]        rst_v [7] = '{8'h40, 8'h80, 8'h33, 8'h40, 8'h80, 8'h00, 8'h00};

  hdc_host_model i_hdc_host_model (
    .ref_clk(ref_clk),
    .req    (req)
  );

  hdc_core #(
    .CAL_CYCLES   (8),
    .HALF_UNIT_CYC(2)
  ) i_hdc_core (
    .ref_clk      (ref_clk),
    .nrst         (nrst),
    .en           (en),
    .req          (req),
    .pwm_in       (pwm_in),
    .pwm_duty     (8'hc0),
    .zero_cross   (pwm_in),
    .brake_req    (brake_req),
    .res_lock     (res_lock),
    .bemf_ok      (bemf_ok),
    .cal_comp_in  (comp_in),
    .cal_bemf_in  (bemf_in),
    .res_period_in(per_in),
    .reg_rdata    (reg_rdata),
    .reg_rvalid   (reg_rvalid),
    .drive_level  (drive_level),
    .drive_neg    (drive_neg),
    .comm_phase   (comm_phase),
    .reverse_drive(reverse_drive),
    .cal_busy     (cal_busy)
  );

  always #12.5 ref_clk = ~ref_clk;

  // The pulse-width input rises every second clock while enabled; it is also the zero-cross.
  always @(negedge ref_clk) begin
    if (pwm_run) pwm_in <= ~pwm_in;
  end

  // A hang is cut short well beyond the expected run length.
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 6000) begin
      fail_count++;
      results();
    end
  end

  // Each read answer is matched against the oldest note left by the driver.
  always @(negedge ref_clk) begin
    if (reg_rvalid === 1'b1 && exp_q.size() > 0) begin
      note = exp_q.pop_front();
      check("read data", note[7:0], reg_rdata & note[15:8]);
    end
  end

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_hdc_host_model.put('{wr: 1'b1, rd: 1'b0, addr: a, wdata: d});
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] v, input logic [7:0] m);
    exp_q.push_back({m, v & m});
    i_hdc_host_model.put('{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00});
  endtask

  // Waits until queued requests are taken and the two-stage drive path has settled.
  task automatic sync();
    while (i_hdc_host_model.pending() > 0) @(posedge ref_clk);
    repeat (4) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask

  // Measures clocks between commutation flips; the last of three intervals is whole.
  task automatic gap_check(input int exp);
    logic p;
    int   n;
    for (int j = 0; j < 3; j++) begin
      p = comm_phase;
      n = 0;
      while (comm_phase === p && n < 400) begin
        @(negedge ref_clk);
        n++;
      end
    end
    check("phase gap", 8'(exp), 8'(n));
  endtask

  // Mode 0,1 open loop signed/unsigned, 2 closed unidirectional, 3,4 closed bidirectional.
  function automatic logic [8:0] exp_drive(input int md, input logic [7:0] r);
    int v;
    int m;
    v = (md == 0 || md == 3) ? int'($signed(r)) : int'(r) - 128;
    if (md < 2) m = (v == 0) ? 0 : ((v < 0 ? -v : v) * 160 + 160) >> 7;
    else if (md == 2) m = (int'(r) * 144 + 144) >> 8;
    else m = (v <= 0) ? 0 : (v * 144 + 144) >> 7;
    if (m > 160) m = 160;
    return {md < 2 && v < 0, 8'(m)};
  endfunction

  task automatic results();
    $display("Comparisons %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    void'($urandom(32'h0d03594b));
    repeat (20) @(negedge ref_clk);
    nrst = 1'b1;
    for (int i = 0; i < 7; i++) rd(rst_a[i], rst_v[i], 8'hff);
    rd(8'h00, 8'ha0, 8'he8);
    wr(8'h16, 8'h90);
    wr(8'h17, 8'ha0);
    wr(8'h1a, 8'h00);
    wr(8'h01, 8'h05);
    for (int c = 0; c < 5; c++) begin
      wr(8'h1d, cfg_tab[c]);
      for (int k = 0; k < 6; k++) begin
        raw = (k < 4) ? raw_tab[k] : 8'($urandom);
        wr(8'h02, raw);
        sync();
        e = exp_drive(c, raw);
        check("drive level", e[7:0], drive_level);
        check("drive sign", {7'h0, e[8]}, {7'h0, drive_neg});
        check("reverse", {7'h0, e[8]}, {7'h0, reverse_drive});
      end
    end
    brake_req = 1'b1;
    sync();
    check("brake level", 8'ha0, drive_level);
    check("brake sign", 8'h01, {7'h0, drive_neg});
    brake_req = 1'b0;
    for (int i = 0; i < 4; i++) begin
      bemf_ok = cal_tab[i][2];
      res_lock = cal_tab[i][1];
      comp_in = 8'($urandom);
      bemf_in = 8'($urandom);
      per_in = 8'($urandom);
      wr(8'h1a, {cal_tab[i][3], 7'h00});
      wr(8'h01, 8'h07);
      wr(8'h0c, 8'h01);
      wr(8'h0c, 8'h00);
      for (int k = 0; k < 3; k++) rd(8'h0c, 8'h01, 8'h01);
      sync();
      for (int n = 0; n < 100 && cal_busy !== 1'b0; n++) @(negedge ref_clk);
      rd(8'h0c, 8'h00, 8'h01);
      rd(8'h00, {4'h0, cal_tab[i][0], 3'h0}, 8'h08);
      rd(8'h18, comp_in, 8'hff);
      rd(8'h19, bemf_in, 8'hff);
      if (cal_tab[i][3]) rd(8'h22, per_in, 8'hff);
      sync();
    end
    en = 1'b0;
    wr(8'h18, ~comp_in);
    rd(8'h18, comp_in, 8'hff);
    sync();
    en = 1'b1;
    wr(8'h01, 8'h40);
    rd(8'h18, comp_in, 8'hff);
    wr(8'h1a, 8'h80);
    wr(8'h1d, 8'h01);
    wr(8'h20, 8'h02);
    wr(8'h02, 8'h40);
    wr(8'h01, 8'h05);
    sync();
    gap_check(4);
    wr(8'h01, 8'h03);
    pwm_run = 1'b1;
    sync();
    gap_check(128);
    wr(8'h1d, 8'h00);
    sync();
    gap_check(2);
    pwm_run = 1'b0;
    for (int i = 0; i < 5; i++) wr(8'h1a - 8'(i), fz[4 - i]);
    wr(8'h1e, 8'h01);
    rd(8'h1e, 8'h04, 8'h04);
    wr(8'h16, 8'h11);
    wr(8'h1e, 8'h01);
    wr(8'h01, 8'h80);
    sync();
    for (int i = 0; i < 5; i++) rd(8'h16 + 8'(i), fz[i], 8'hff);
    rd(8'h1e, 8'h04, 8'h04);
    sync();
    results();
  end
endmodule
